// ==== core/serial_rx.sv ====
// Asynchronous serial receiver with 16x oversampling and break detection
`timescale 1ns/1ps
`include "serial_rx_consts.svh"
module serial_rx (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  // Line and tick
  input wire logic RX_LINE,
  input wire logic OVERSAMPLE_TICK,
  // Configuration
  input wire logic NINE_BIT_MODE,
  input wire logic LONG_BREAK_DETECT_ENABLE,
  input wire logic RX_POLARITY_INVERT,
  input wire logic RX_FULL_IRQ_ENABLE,
  input wire logic ERROR_IRQ_ENABLE,
  // Software accesses (one-cycle strobes)
  input wire logic STATUS_READ,
  input wire logic DATA_READ,
  input wire logic LONG_BREAK_CLEAR,
  // Status and data
  output logic [7:0] SERIAL_DATA_REG,
  output logic RX_NINTH_BIT,
  output logic RX_FULL_FLAG,
  output logic NOISE_FLAG,
  output logic FRAMING_ERROR_FLAG,
  output logic PARITY_ERROR_FLAG,
  output logic OVERRUN_FLAG,
  output logic RX_ACTIVE_FLAG,
  output logic LONG_BREAK_DETECTED_FLAG,
  // Interrupts
  output logic RX_IRQ,
  output logic ERR_IRQ,
  output logic TX_IRQ
);
  // Word in the buffer: break, framing, noise, ninth bit, data
  localparam int WORD_W = 12;

  serial_rx_pkg::rx_state_t state_reg;
  serial_rx_pkg::rx_state_t state_next;
  logic line_sync;
  logic line;
  logic [2:0] hist_reg;
  logic [4:0] tick_reg;
  logic [4:0] tick_next;
  logic [2:0] samp_reg;
  logic [3:0] bit_idx_reg;
  logic [8:0] shift_reg;
  logic prev_bit_reg;
  logic frame_noise_reg;
  logic [7:0] low_run_reg;
  logic flags_armed_reg;
  logic in_valid_reg;
  logic [WORD_W-1:0] in_word_reg;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [WORD_W-1:0] buf_out_data;
  logic serial_overrun_reg;

  function automatic logic vote(input logic [2:0] s);
    return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  function automatic logic disagree(input logic [2:0] s);
    return (s != 3'b000) && (s != 3'b111);
  endfunction

  serial_rx_sync u_sync (
    .clk(CLK),
    .nrst(NRST),
    .ce(CE),
    .d(RX_LINE),
    .q(line_sync)
  );

  assign line = line_sync ^ RX_POLARITY_INVERT;

  // Tick-level decodes
  wire tick = CE && OVERSAMPLE_TICK;
  wire falling = tick && (hist_reg == `RX_IDLE_HISTORY) && !line;
  wire at_s3 = (tick_reg == `RX_START_SAMPLE_A);
  wire at_s5 = (tick_reg == `RX_START_SAMPLE_B);
  wire at_s7 = (tick_reg == `RX_START_SAMPLE_C);
  wire at_s8 = (tick_reg == `RX_DATA_SAMPLE_A);
  wire at_s9 = (tick_reg == `RX_DATA_SAMPLE_B);
  wire at_s10 = (tick_reg == `RX_DATA_SAMPLE_C);
  wire bit_end = (tick_reg == `RX_TICKS_PER_BIT);
  // Samples 3,5,7 complete on tick 7 with the current line level
  wire [2:0] start_s = {samp_reg[1:0], line};
  wire start_ok = (start_s == 3'b000) || (start_s == 3'b001) || (start_s == 3'b010)
    || (start_s == 3'b100);
  wire [2:0] mid_s = {samp_reg[1:0], line};
  wire mid_bit = vote(mid_s);
  wire mid_noise = disagree(mid_s);
  wire last_data = (bit_idx_reg == (NINE_BIT_MODE ? 4'd8 : 4'd7));
  // Data one-to-zero change: the edge sample becomes tick one of the new bit
  wire data_edge = (state_reg == serial_rx_pkg::RX_DATA) && tick && !line
    && hist_reg[0] && prev_bit_reg;
  // Late edge ends the current bit early (fast sender)
  wire data_resync = data_edge && (tick_reg > `RX_DATA_SAMPLE_C);
  // Early edge realigns a bit already begun (slow sender)
  wire data_early = data_edge && (tick_reg < `RX_DATA_SAMPLE_A);
  wire [4:0] break_len = (NINE_BIT_MODE ? `RX_BREAK_BITS_9 : `RX_BREAK_BITS_8)
    + (LONG_BREAK_DETECT_ENABLE ? `RX_LONG_BREAK_EXTRA : 5'd0);
  wire stop_done = (state_reg == serial_rx_pkg::RX_STOP) && tick && at_s10;
  wire stop_bit = vote(mid_s);
  wire is_break = stop_done && !stop_bit && (shift_reg == 9'h000);
  // Threshold in samples: bit times times sixteen
  wire [7:0] break_ticks = {break_len[3:0], 4'h0};
  wire long_break = tick && !line && (low_run_reg == break_ticks - 8'd1);

  always_comb
  begin
    state_next = state_reg;
    tick_next = tick_reg + 5'd1;
    case (state_reg)
      serial_rx_pkg::RX_IDLE:
      begin
        // The falling sample itself is tick one of the start bit
        tick_next = falling ? 5'd2 : 5'd1;
        if (falling) state_next = serial_rx_pkg::RX_START;
      end
      serial_rx_pkg::RX_START:
      begin
        if (at_s7 && !start_ok)
        begin
          state_next = serial_rx_pkg::RX_IDLE;
          tick_next = 5'd0;
        end
        else if (bit_end)
        begin
          state_next = serial_rx_pkg::RX_DATA;
          tick_next = 5'd1;
        end
      end
      serial_rx_pkg::RX_DATA:
      begin
        if (data_resync)
        begin
          tick_next = 5'd2;
          if (last_data) state_next = serial_rx_pkg::RX_STOP;
        end
        else if (data_early) tick_next = 5'd2;
        else if (bit_end)
        begin
          tick_next = 5'd1;
          if (last_data) state_next = serial_rx_pkg::RX_STOP;
        end
      end
      serial_rx_pkg::RX_STOP:
      begin
        if (at_s10)
        begin
          state_next = serial_rx_pkg::RX_IDLE;
          tick_next = 5'd0;
        end
      end
      default:
      begin
        state_next = serial_rx_pkg::RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_reg <= serial_rx_pkg::RX_IDLE;
      tick_reg <= 5'd0;
      hist_reg <= `RX_IDLE_HISTORY;
    end
    else if (tick)
    begin
      state_reg <= state_next;
      tick_reg <= tick_next;
      hist_reg <= {hist_reg[1:0], line};
    end
  end

  // Sample capture and bit assembly
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      samp_reg <= 3'h0;
      bit_idx_reg <= 4'h0;
      shift_reg <= `RX_DATA_RESET;
      prev_bit_reg <= 1'b0;
      frame_noise_reg <= 1'b0;
    end
    else if (tick)
    begin
      if (at_s3 || at_s5 || at_s8 || at_s9) samp_reg <= {samp_reg[1:0], line};
      if (state_reg == serial_rx_pkg::RX_IDLE)
      begin
        bit_idx_reg <= 4'h0;
        frame_noise_reg <= 1'b0;
        prev_bit_reg <= 1'b0;
      end
      if (state_reg == serial_rx_pkg::RX_START)
      begin
        if (at_s7 && start_ok && start_s != 3'b000) frame_noise_reg <= 1'b1;
        if (at_s10 && mid_s != 3'b000) frame_noise_reg <= 1'b1;
      end
      if (state_reg == serial_rx_pkg::RX_DATA && at_s10)
      begin
        shift_reg[bit_idx_reg] <= mid_bit;
        prev_bit_reg <= mid_bit;
        if (mid_noise) frame_noise_reg <= 1'b1;
      end
      if (state_reg == serial_rx_pkg::RX_DATA && (bit_end || data_resync) && !data_early)
        bit_idx_reg <= bit_idx_reg + 4'h1;
      if (state_reg == serial_rx_pkg::RX_START && bit_end) shift_reg <= `RX_DATA_RESET;
    end
  end

  // Low run length in samples; counts across frame ends, saturates
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST) low_run_reg <= 8'h00;
    else if (tick)
    begin
      if (line) low_run_reg <= 8'h00;
      else if (low_run_reg != 8'hff) low_run_reg <= low_run_reg + 8'h01;
    end
  end

  // Completed frame enters the buffer unless long break detection is on; a stall there counts as overrun
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      in_valid_reg <= 1'b0;
      in_word_reg <= '0;
      serial_overrun_reg <= 1'b0;
    end
    else if (CE)
    begin
      if (in_valid_reg && buf_in_ready) in_valid_reg <= 1'b0;
      // Handed to the flag on take; a new overrun in that cycle wins
      if (buf_out_valid && !RX_FULL_FLAG) serial_overrun_reg <= 1'b0;
      if (stop_done && !LONG_BREAK_DETECT_ENABLE)
      begin
        if (in_valid_reg && !buf_in_ready) serial_overrun_reg <= 1'b1;
        else
        begin
          in_valid_reg <= 1'b1;
          in_word_reg <= {is_break, !stop_bit, frame_noise_reg || disagree(mid_s),
            is_break ? `RX_DATA_RESET : shift_reg};
        end
      end
    end
  end

  wire take = CE && buf_out_valid && !RX_FULL_FLAG;

  serial_rx_buffer #(.WIDTH(WORD_W)) u_buf (
    .clk(CLK),
    .nrst(NRST),
    .ce(CE),
    .in_valid(in_valid_reg),
    .in_ready(buf_in_ready),
    .in_data(in_word_reg),
    .out_valid(buf_out_valid),
    .out_ready(take),
    .out_data(buf_out_data)
  );

  // Status then data read clears; an arriving character wins
  logic status_seen_reg;
  wire sw_clear = DATA_READ && status_seen_reg;

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      status_seen_reg <= 1'b0;
      SERIAL_DATA_REG <= 8'h00;
      RX_NINTH_BIT <= 1'b0;
      RX_FULL_FLAG <= 1'b0;
      NOISE_FLAG <= 1'b0;
      FRAMING_ERROR_FLAG <= 1'b0;
      PARITY_ERROR_FLAG <= 1'b0;
      OVERRUN_FLAG <= 1'b0;
      RX_ACTIVE_FLAG <= 1'b0;
      LONG_BREAK_DETECTED_FLAG <= 1'b0;
      RX_IRQ <= 1'b0;
      ERR_IRQ <= 1'b0;
      TX_IRQ <= 1'b0;
    end
    else if (CE)
    begin
      if (STATUS_READ) status_seen_reg <= RX_FULL_FLAG || FRAMING_ERROR_FLAG || NOISE_FLAG
        || OVERRUN_FLAG;
      else if (DATA_READ) status_seen_reg <= 1'b0;
      if (take)
      begin
        SERIAL_DATA_REG <= buf_out_data[7:0];
        RX_NINTH_BIT <= buf_out_data[`RX_NINTH_BIT_POS] & NINE_BIT_MODE;
        RX_FULL_FLAG <= 1'b1;
        FRAMING_ERROR_FLAG <= buf_out_data[10];
        NOISE_FLAG <= buf_out_data[9];
        OVERRUN_FLAG <= serial_overrun_reg;
      end
      else if (sw_clear)
      begin
        RX_FULL_FLAG <= 1'b0;
        FRAMING_ERROR_FLAG <= 1'b0;
        NOISE_FLAG <= 1'b0;
        PARITY_ERROR_FLAG <= 1'b0;
        OVERRUN_FLAG <= 1'b0;
      end
      RX_ACTIVE_FLAG <= (state_reg != serial_rx_pkg::RX_IDLE);
      if (long_break && LONG_BREAK_DETECT_ENABLE) LONG_BREAK_DETECTED_FLAG <= 1'b1;
      else if (LONG_BREAK_CLEAR) LONG_BREAK_DETECTED_FLAG <= 1'b0;
      RX_IRQ <= (RX_FULL_FLAG && RX_FULL_IRQ_ENABLE) || LONG_BREAK_DETECTED_FLAG;
      ERR_IRQ <= ERROR_IRQ_ENABLE && (FRAMING_ERROR_FLAG || NOISE_FLAG
        || PARITY_ERROR_FLAG || OVERRUN_FLAG);
      TX_IRQ <= 1'b0;
    end
  end

  a_irq_follows_full: assert property (@(posedge CLK) disable iff (!NRST)
    CE && RX_FULL_FLAG && RX_FULL_IRQ_ENABLE |=> RX_IRQ)
    else $error("receive interrupt missing");
  a_fe_with_full: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(FRAMING_ERROR_FLAG) |-> $rose(RX_FULL_FLAG))
    else $error("framing error without full flag");
  a_break_clears_data: assert property (@(posedge CLK) disable iff (!NRST)
    take && buf_out_data[11] |=> SERIAL_DATA_REG == 8'h00 && FRAMING_ERROR_FLAG)
    else $error("break did not clear data");
  a_start_reject: assert property (@(posedge CLK) disable iff (!NRST)
    state_reg == serial_rx_pkg::RX_START && tick && at_s7 && !start_ok
    |=> state_reg == serial_rx_pkg::RX_IDLE && !frame_noise_reg)
    else $error("rejected start not restarted");
  a_start_noise: assert property (@(posedge CLK) disable iff (!NRST)
    state_reg == serial_rx_pkg::RX_START && tick && at_s7 && start_s == 3'b010
    |=> frame_noise_reg)
    else $error("noisy start not flagged");
  a_data_vote: assert property (@(posedge CLK) disable iff (!NRST)
    state_reg == serial_rx_pkg::RX_DATA && tick && at_s10 && mid_s == 3'b011
    |=> frame_noise_reg && prev_bit_reg)
    else $error("data vote wrong");
  a_tick_bound: assert property (@(posedge CLK) disable iff (!NRST)
    tick_reg <= `RX_TICKS_PER_BIT)
    else $error("tick count beyond sixteen");
  a_long_blocks: assert property (@(posedge CLK) disable iff (!NRST)
    LONG_BREAK_DETECT_ENABLE && stop_done && !in_valid_reg |=> !in_valid_reg)
    else $error("long break mode let frame through");
endmodule // serial_rx

// ==== core/serial_rx_buffer.sv ====
// Two-entry valid/ready buffer for received characters
`timescale 1ns/1ps
module serial_rx_buffer #(
  parameter int WIDTH = 12
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_reg [0:1];
  logic [1:0] count_reg;
  logic rd_ptr_reg;
  logic wr_ptr_reg;
  wire push = ce && in_valid && in_ready;
  wire pop = ce && out_valid && out_ready;

  initial
  begin
    if (WIDTH < 1) $error("serial_rx_buffer: WIDTH must be positive");
  end

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      count_reg <= 2'h0;
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
    end
    else
    begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop) count_reg <= count_reg + 2'h1;
      else if (pop && !push) count_reg <= count_reg - 2'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push) mem_reg[wr_ptr_reg] <= in_data;
  end

  a_buffer_bound: assert property (@(posedge clk) disable iff (!nrst) count_reg <= 2'h2)
    else $error("buffer count out of range");
endmodule // serial_rx_buffer

// ==== core/serial_rx_consts.svh ====
// Timing counts, field positions and reset values of the serial receiver
`ifndef SERIAL_RX_CONSTS_SVH
`define SERIAL_RX_CONSTS_SVH
`define RX_TICKS_PER_BIT 5'd16
`define RX_START_SAMPLE_A 5'd3
`define RX_START_SAMPLE_B 5'd5
`define RX_START_SAMPLE_C 5'd7
`define RX_DATA_SAMPLE_A 5'd8
`define RX_DATA_SAMPLE_B 5'd9
`define RX_DATA_SAMPLE_C 5'd10
`define RX_BREAK_BITS_8 5'd10
`define RX_BREAK_BITS_9 5'd11
`define RX_LONG_BREAK_EXTRA 5'd1
`define RX_NINTH_BIT_POS 8
`define RX_DATA_RESET 9'h000
`define RX_IDLE_HISTORY 3'h7
`endif

// ==== core/serial_rx_pkg.sv ====
// Types shared by the serial receiver files
package serial_rx_pkg;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;
endpackage

// ==== core/serial_rx_sync.sv ====
// Two-flop synchroniser for the receive line
`timescale 1ns/1ps
module serial_rx_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  logic q_reg;
  assign q = q_reg;
  // Line idles high, so both stages reset to one
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 1'b1;
      q_reg <= 1'b1;
    end
    else if (ce)
    begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end
endmodule // serial_rx_sync

// ==== tb/serial_rx_tb.sv ====
// Self-checking testbench of the serial receiver
`timescale 1ns/1ps
module serial_rx_tb;
  logic clk, nrst, tick, nine, lbk, inv, rx_full_irq_enable, eie, sread, dread, lbclr, line;
  logic [7:0] rx_data;
  logic ninth, full, noise, ferr, perr, ovr, active, lbflag, rirq, eirq, tirq;
  int miscompares;
  int n_checks;
  always #50 clk = ~clk;
  // One tick every two clocks
  always @(negedge clk) tick <= ~tick;
  serial_tx_model serial_tx_model_inst (.clk(clk), .tick(tick), .invert(inv), .line(line));
  serial_rx serial_rx_inst (
    .CLK(clk), .NRST(nrst), .CE(1'b1), .RX_LINE(line), .OVERSAMPLE_TICK(tick),
    .NINE_BIT_MODE(nine), .LONG_BREAK_DETECT_ENABLE(lbk), .RX_POLARITY_INVERT(inv),
    .RX_FULL_IRQ_ENABLE(rx_full_irq_enable), .ERROR_IRQ_ENABLE(eie), .STATUS_READ(sread),
    .DATA_READ(dread), .LONG_BREAK_CLEAR(lbclr), .SERIAL_DATA_REG(rx_data),
    .RX_NINTH_BIT(ninth), .RX_FULL_FLAG(full), .NOISE_FLAG(noise),
    .FRAMING_ERROR_FLAG(ferr), .PARITY_ERROR_FLAG(perr), .OVERRUN_FLAG(ovr),
    .RX_ACTIVE_FLAG(active), .LONG_BREAK_DETECTED_FLAG(lbflag), .RX_IRQ(rirq),
    .ERR_IRQ(eirq), .TX_IRQ(tirq));
  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic chk(input logic [8:0] d, input logic f, input logic n, input logic e);
    check("data", {ninth, rx_data}, d);
    check("full", {8'h00, full}, {8'h00, f});
    check("noise", {8'h00, noise}, {8'h00, n});
    check("framing", {8'h00, ferr}, {8'h00, e});
  endtask
  // Status read then data read, one-cycle strobes
  task automatic clear();
    @(negedge clk) sread = 1'b1;
    @(negedge clk) sread = 1'b0;
    dread = 1'b1;
    @(negedge clk) dread = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #5ms;
    miscompares++;
    test_done();
  end
  initial
  begin
    clk = 0; nrst = 0; tick = 0; nine = 0; lbk = 0; inv = 0; rx_full_irq_enable = 0; eie = 0;
    sread = 0; dread = 0; lbclr = 0; miscompares = 0; n_checks = 0;
    repeat (3) @(negedge clk);
    nrst = 1;
    repeat (3) @(negedge clk);
    check("reset", {1'b0, full, noise, ferr, ovr, lbflag, rirq, eirq, tirq}, 9'h000);
    serial_tx_model_inst.send({1'b1, 8'ha5}, 9);
    chk(9'h0a5, 1, 0, 0);
    check("rx_irq", {8'h00, rirq}, 9'h000);
    clear();
    check("full", {8'h00, full}, 9'h000);
    rx_full_irq_enable = 1;
    serial_tx_model_inst.send({1'b1, 8'h3c}, 9, 16, 4, 8, 1);
    chk(9'h03c, 1, 1, 0);
    check("rx_irq", {8'h00, rirq}, 9'h001);
    clear();
    check("noise", {8'h00, noise}, 9'h000);
    serial_tx_model_inst.send({1'b1, 8'h81}, 9, 16, 0, 4, 1);
    chk(9'h081, 1, 1, 0);
    clear();
    serial_tx_model_inst.send({1'b1, 8'h42}, 9, 16, 0, 8, 2);
    chk(9'h042, 1, 1, 0);
    clear();
    serial_tx_model_inst.low_pulse(2);
    check("rejected", {7'h00, full, noise}, 9'h000);
    serial_tx_model_inst.send({1'b1, 8'h5a}, 9);
    chk(9'h05a, 1, 0, 0);
    clear();
    serial_tx_model_inst.send({1'b1, 8'hf0}, 9, 16, 9, 8, 1);
    chk(9'h0f0, 1, 1, 0);
    clear();
    eie = 1;
    serial_tx_model_inst.send({1'b0, 8'h7e}, 9);
    chk(9'h07e, 1, 0, 1);
    check("err_irq", {8'h00, eirq}, 9'h001);
    clear();
    check("err_irq", {7'h00, ferr, eirq}, 9'h000);
    serial_tx_model_inst.send(16'h0000, 9);
    chk(9'h000, 1, 0, 1);
    clear();
    nine = 1;
    serial_tx_model_inst.send({1'b1, 9'h1c3}, 10);
    chk(9'h1c3, 1, 0, 0);
    clear();
    nine = 0;
    serial_tx_model_inst.send({1'b1, 8'h55}, 9, 17);
    chk(9'h055, 1, 0, 0);
    clear();
    inv = 1;
    repeat (64) @(negedge clk);
    serial_tx_model_inst.send({1'b1, 8'h96}, 9);
    chk(9'h096, 1, 0, 0);
    clear();
    inv = 0;
    repeat (64) @(negedge clk);
    lbk = 1;
    serial_tx_model_inst.send(16'h0000, 9);
    check("long_break", {8'h00, lbflag}, 9'h000);
    serial_tx_model_inst.send(16'h0000, 11);
    check("long_break", {8'h00, lbflag}, 9'h001);
    check("blocked", {7'h00, full, ferr}, 9'h000);
    @(negedge clk) lbclr = 1;
    @(negedge clk) lbclr = 0;
    lbk = 0;
    @(negedge clk);
    check("long_break", {8'h00, lbflag}, 9'h000);
    // Four words fit (register, buffer, staging); the fifth is dropped
    for (int i = 1; i <= 5; i++)
      serial_tx_model_inst.send({1'b1, 8'h11 * i[7:0]}, 9);
    chk(9'h011, 1, 0, 0);
    check("overrun", {8'h00, ovr}, 9'h000);
    clear();
    check("overrun", {8'h00, ovr}, 9'h001);
    chk(9'h022, 1, 0, 0);
    repeat (3) clear();
    check("drained", {6'h00, full, perr, tirq}, 9'h000);
    test_done();
  end
endmodule // serial_rx_tb

// ==== tb/serial_tx_model.sv ====
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module serial_tx_model (
  // Clock, tick and polarity
  input wire logic clk,
  input wire logic tick,
  input wire logic invert,
  // Line
  output logic line
);
  logic level;
  assign line = level ^ invert;
  initial level = 1'b1;
  task automatic wait_tick();
    @(posedge clk iff tick);
    @(negedge clk);
  endtask
  // Start bit, then nb bits lsb first (stop included); gl ticks flipped from gtick of gbit
  task automatic send(input logic [15:0] bits, input int nb, input int tpb = 16,
                      input int gbit = -1, input int gtick = 0, input int gl = 0);
    logic [16:0] frame;
    frame = {bits, 1'b0};
    for (int b = 0; b <= nb; b++)
      for (int t = 0; t < tpb; t++)
      begin
        level = frame[b] ^ (b == gbit && t >= gtick && t < gtick + gl);
        wait_tick();
      end
    level = 1'b1;
    // Long idle so the next start has three high samples before it
    repeat (48) wait_tick();
  endtask
  task automatic low_pulse(input int n);
    level = 1'b0;
    repeat (n) wait_tick();
    level = 1'b1;
    repeat (32) wait_tick();
  endtask
endmodule // serial_tx_model
